/* hdl/mst_down_counter.sv */
// Eight-bit slot count with same-cycle software load
`timescale 1ns/1ps
module mst_down_counter
    import mst_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Control
    input  wire logic                 restore,
    input  wire logic                 count_edge,
    input  wire logic                 free_run,
    input  wire logic                 wr_en,
    input  wire logic [MST_CNT_W-1:0] wr_data,
    // Status
    output logic [MST_CNT_W-1:0]      count,
    output logic                      reached_zero
);
    logic [MST_CNT_W-1:0] cnt_ff;
    logic [MST_CNT_W-1:0] nxt_cnt;
    logic [MST_CNT_W-1:0] base;

    always_comb begin
        base         = wr_en ? wr_data : cnt_ff;
        nxt_cnt      = base;
        reached_zero = 1'b0;
        if (restore) begin
            nxt_cnt = MST_RST_COUNT;
        end else if (count_edge) begin
            if (base == MST_CNT_ZERO) begin
                nxt_cnt = free_run ? MST_CNT_MAX : MST_CNT_ZERO;
            end else begin
                nxt_cnt      = base - MST_CNT_ONE;
                reached_zero = (base == MST_CNT_ONE);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= MST_RST_COUNT;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign count = cnt_ff;
endmodule

/* hdl/mst_pkg.sv */
// Constants, field layout and carrier types of the MAC slot timer
package mst_pkg;

    // Register addresses on the special function register bus
    localparam logic [7:0] MST_ADDR_COUNT     = 8'h9c;
    localparam logic [7:0] MST_ADDR_PRESCALE  = 8'h9d;
    localparam logic [7:0] MST_ADDR_CONTROL   = 8'h9e;

    // Reset values
    localparam logic [7:0] MST_RST_COUNT      = 8'h00;
    localparam logic [7:0] MST_RST_PRESCALE   = 8'h00;
    localparam logic [1:0] MST_RST_TIP        = 2'h0;

    // Control register field positions
    localparam int         MST_CTL_EXPIRY     = 6;
    localparam int         MST_CTL_IRQ_EN     = 4;
    localparam int         MST_CTL_FREE_RUN   = 2;
    localparam int         MST_CTL_TIP_MSB    = 1;
    localparam int         MST_CTL_TIP_LSB    = 0;

    // Count and prescaler geometry
    localparam int         MST_CNT_W          = 8;
    localparam int         MST_PRESC_W        = 18;
    localparam int         MST_PRESC_LOW_W    = 10;
    localparam logic [7:0] MST_CNT_MAX        = 8'hff;
    localparam logic [7:0] MST_CNT_ZERO       = 8'h00;
    localparam logic [7:0] MST_CNT_ONE        = 8'h01;
    localparam logic [8:0] MST_PR_ZERO_AS     = 9'h100;

    // Prescaler increment per tick: 1024 divided by the multiplier
    localparam logic [MST_PRESC_W:0] MST_STEP_X64   = 19'h00010;
    localparam logic [MST_PRESC_W:0] MST_STEP_X128  = 19'h00008;
    localparam logic [MST_PRESC_W:0] MST_STEP_X256  = 19'h00004;
    localparam logic [MST_PRESC_W:0] MST_STEP_X1024 = 19'h00001;

    typedef enum logic [1:0] {
        MST_MUL_64   = 2'h0,
        MST_MUL_128  = 2'h1,
        MST_MUL_256  = 2'h2,
        MST_MUL_1024 = 2'h3
    } mst_mul_e;

    // Tick generator state, one-hot
    typedef enum logic [1:0] {
        MST_GEN_IDLE = 2'b01,
        MST_GEN_RUN  = 2'b10
    } mst_gen_e;

    typedef struct packed {
        logic       free_run;
        logic       irq_en;
        mst_mul_e   prescale_multiplier_sel;
        logic [7:0] prescale;
    } mst_cfg_s;

    typedef struct packed {
        logic irq_flag_set;
        logic irq_req;
        logic dma_trig;
    } mst_evt_s;

endpackage

/* hdl/mst_prescaler.sv */
// Tick-aligned 18-bit prescaler producing the prescaled count edge
`timescale 1ns/1ps
module mst_prescaler
    import mst_pkg::*;
(
    // Clock and reset
    input  wire logic     sys_clk,
    input  wire logic     rst_n,
    // Control
    input  wire logic     run,
    input  wire logic     tick_en,
    input  wire mst_mul_e prescale_multiplier_sel,
    input  wire logic [7:0] prescale,
    // Prescaled edge, same cycle as the wrap
    output logic          presc_edge
);
    logic [MST_PRESC_W-1:0] presc_ff;
    logic [MST_PRESC_W-1:0] nxt_presc;
    logic [MST_PRESC_W:0]   step;
    logic [MST_PRESC_W:0]   sum;
    logic [MST_PRESC_W:0]   terminal;
    logic [8:0]             pr_eff;

    always_comb begin
        case (prescale_multiplier_sel)
            MST_MUL_64:   step = MST_STEP_X64;
            MST_MUL_128:  step = MST_STEP_X128;
            MST_MUL_256:  step = MST_STEP_X256;
            MST_MUL_1024: step = MST_STEP_X1024;
            default:      step = MST_STEP_X1024;
        endcase
        pr_eff     = (prescale == MST_CNT_ZERO) ? MST_PR_ZERO_AS : {1'b0, prescale};
        terminal   = {pr_eff, {MST_PRESC_LOW_W{1'b0}}};
        sum        = {1'b0, presc_ff} + step;
        nxt_presc  = presc_ff;
        presc_edge = 1'b0;
        if (!run) begin
            nxt_presc = '0;
        end else if (tick_en) begin
            if (sum >= terminal) begin
                nxt_presc  = '0;
                presc_edge = 1'b1;
            end else begin
                nxt_presc = sum[MST_PRESC_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= '0;
        end else begin
            presc_ff <= nxt_presc;
        end
    end
endmodule

/* hdl/mst_slot_timer.sv */
// MAC slot timer top: SFR registers, tick generator control and event outputs
`timescale 1ns/1ps
module mst_slot_timer
    import mst_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata,
    // Clock control and power management
    input  wire logic       tick_en,
    input  wire logic       deep_sleep_resume,
    // Central interrupt unmask bit for this timer
    input  wire logic       expiry_irq_unmask,
    // Event outputs
    output logic            expiry_irq_flag,
    output logic            irq_req,
    output logic            expiry_dma_trigger,
    output logic            expiry_flag
);
    // Configuration registers
    mst_cfg_s    cfg_ff;
    mst_cfg_s    nxt_cfg;
    logic        expiry_ff;
    logic        nxt_expiry;

    // Tick generator
    mst_gen_e    gen_ff;
    mst_gen_e    nxt_gen;
    logic        run_req;
    logic        presc_run;
    logic        presc_edge;

    // Count
    logic [7:0]  slot_count_value;
    logic        reached_zero;
    logic        wr_count;
    logic        wr_prescale;
    logic        wr_control;

    // Events and read data
    mst_evt_s    evt_ff;
    mst_evt_s    nxt_evt;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [7:0]  ctl_view;

    // Write decode
    always_comb begin
        wr_count    = sfr_wr && (sfr_addr == MST_ADDR_COUNT);
        wr_prescale = sfr_wr && (sfr_addr == MST_ADDR_PRESCALE);
        wr_control  = sfr_wr && (sfr_addr == MST_ADDR_CONTROL);
    end

    // Control and prescale registers
    always_comb begin
        nxt_cfg    = cfg_ff;
        nxt_expiry = expiry_ff;
        if (deep_sleep_resume) begin
            nxt_cfg.free_run = 1'b0;
            nxt_cfg.irq_en   = 1'b0;
            nxt_cfg.prescale_multiplier_sel      = mst_mul_e'(MST_RST_TIP);
            nxt_cfg.prescale = MST_RST_PRESCALE;
            nxt_expiry       = 1'b0;
        end else begin
            if (wr_prescale) begin
                nxt_cfg.prescale = sfr_wdata;
            end
            // Reserved bits 7, 5 and 3 are not stored and read back as zero
            if (wr_control) begin
                nxt_cfg.free_run = sfr_wdata[MST_CTL_FREE_RUN];
                nxt_cfg.irq_en   = sfr_wdata[MST_CTL_IRQ_EN];
                nxt_cfg.prescale_multiplier_sel      = mst_mul_e'(sfr_wdata[MST_CTL_TIP_MSB:MST_CTL_TIP_LSB]);
                if (!sfr_wdata[MST_CTL_EXPIRY]) begin
                    nxt_expiry = 1'b0;
                end
                // A written 1 leaves the flag as it is
            end
            // Setting comes last so a coincident clearing write loses
            if (reached_zero) begin
                nxt_expiry = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff    <= '{free_run: 1'b0, irq_en: 1'b0, prescale_multiplier_sel: MST_MUL_64, prescale: MST_RST_PRESCALE};
            expiry_ff <= 1'b0;
        end else begin
            cfg_ff    <= nxt_cfg;
            expiry_ff <= nxt_expiry;
        end
    end

    // Tick generator: runs on demand; leaving idle always restarts the prescaler from zero
    always_comb begin
        run_req = cfg_ff.free_run || (slot_count_value != MST_CNT_ZERO);
        case (gen_ff)
            MST_GEN_IDLE: nxt_gen = run_req ? MST_GEN_RUN : MST_GEN_IDLE;
            MST_GEN_RUN:  nxt_gen = run_req ? MST_GEN_RUN : MST_GEN_IDLE;
            default:      nxt_gen = MST_GEN_IDLE;
        endcase
        if (deep_sleep_resume) begin
            nxt_gen = MST_GEN_IDLE;
        end
        presc_run = (gen_ff == MST_GEN_RUN) && run_req && !deep_sleep_resume;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_ff <= MST_GEN_IDLE;
        end else begin
            gen_ff <= nxt_gen;
        end
    end

    mst_prescaler u_prescaler (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .run        (presc_run),
        .tick_en    (tick_en),
        .prescale_multiplier_sel        (cfg_ff.prescale_multiplier_sel),
        .prescale   (cfg_ff.prescale),
        .presc_edge (presc_edge)
    );

    mst_down_counter u_counter (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .restore      (deep_sleep_resume),
        .count_edge   (presc_edge),
        .free_run     (cfg_ff.free_run),
        .wr_en        (wr_count),
        .wr_data      (sfr_wdata),
        .count        (slot_count_value),
        .reached_zero (reached_zero)
    );

    // Event pulses, registered so they line up with the flag setting
    always_comb begin
        nxt_evt              = '0;
        nxt_evt.dma_trig     = reached_zero && !deep_sleep_resume;
        nxt_evt.irq_flag_set = nxt_evt.dma_trig && cfg_ff.irq_en;
        nxt_evt.irq_req      = nxt_evt.irq_flag_set && expiry_irq_unmask;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_ff <= '0;
        end else begin
            evt_ff <= nxt_evt;
        end
    end

    // Read port: data appears the cycle after the read strobe and holds
    always_comb begin
        ctl_view                                 = '0;
        ctl_view[MST_CTL_EXPIRY]                 = expiry_ff;
        ctl_view[MST_CTL_IRQ_EN]                 = cfg_ff.irq_en;
        ctl_view[MST_CTL_FREE_RUN]               = cfg_ff.free_run;
        ctl_view[MST_CTL_TIP_MSB:MST_CTL_TIP_LSB] = cfg_ff.prescale_multiplier_sel;
        nxt_rdata = rdata_ff;
        if (sfr_rd) begin
            case (sfr_addr)
                MST_ADDR_COUNT:    nxt_rdata = slot_count_value;
                MST_ADDR_PRESCALE: nxt_rdata = cfg_ff.prescale;
                MST_ADDR_CONTROL:  nxt_rdata = ctl_view;
                default:           nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign sfr_rdata          = rdata_ff;
    assign expiry_flag        = expiry_ff;
    assign expiry_dma_trigger = evt_ff.dma_trig;
    assign expiry_irq_flag    = evt_ff.irq_flag_set;
    assign irq_req            = evt_ff.irq_req;
endmodule

/* verification/mst_chk.sv */
// Port-level assertion checker for the MAC slot timer
`timescale 1ns/1ps
module mst_chk
    import mst_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    // Control and events
    input wire logic       tick_en,
    input wire logic       deep_sleep_resume,
    input wire logic       expiry_irq_unmask,
    input wire logic       expiry_irq_flag,
    input wire logic       irq_req,
    input wire logic       expiry_dma_trigger,
    input wire logic       expiry_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic clr_w;
    assign clr_w = sfr_wr && sfr_addr == MST_ADDR_CONTROL && !sfr_wdata[MST_CTL_EXPIRY];
    chk_set_gives_dma: assert property ($rose(expiry_flag) |-> expiry_dma_trigger)
        else $error("flag set without dma");
    chk_dma_needs_flag: assert property (expiry_dma_trigger |-> expiry_flag)
        else $error("dma without flag");
    chk_irqf_with_dma: assert property (expiry_irq_flag |-> expiry_dma_trigger)
        else $error("irq flag without expiry");
    chk_irq_gated: assert property (irq_req |-> expiry_irq_flag &&
        (expiry_irq_unmask || $past(expiry_irq_unmask))) else $error("irq not gated");
    chk_dma_pulse: assert property (expiry_dma_trigger |=> !expiry_dma_trigger [*8])
        else $error("dma too long");
    chk_flag_sticky: assert property (expiry_flag && !clr_w && !deep_sleep_resume |=> expiry_flag)
        else $error("flag dropped");
    chk_ctl_readback: assert property (sfr_rd && sfr_addr == MST_ADDR_CONTROL |=>
        sfr_rdata[6] == $past(expiry_flag) && !sfr_rdata[7]) else $error("control read");
    chk_resume_clears: assert property (deep_sleep_resume |=> !expiry_flag)
        else $error("resume kept flag");
endmodule
bind mst_slot_timer mst_chk u_chk (.sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rd, .sfr_rdata, .tick_en, .deep_sleep_resume, .expiry_irq_unmask,
    .expiry_irq_flag, .irq_req, .expiry_dma_trigger, .expiry_flag);

/* verification/mst_cpu_model.sv */
// Processor core model driving the register port
`timescale 1ns/1ps
module mst_cpu_model
    import mst_pkg::*;
(
    // Clock
    input wire logic       sys_clk,
    // Register port
    output logic [7:0]     sfr_addr,
    output logic           sfr_wr,
    output logic [7:0]     sfr_wdata,
    output logic           sfr_rd,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = (a == MST_ADDR_CONTROL) ? (d & 8'h57) : d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        // Idle bus lines toggle so stale data is never mistaken for valid
        sfr_wdata = ~sfr_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        d = sfr_rdata;
    endtask
endmodule

/* verification/test_mac_slot_timer.sv */
// Self-checking bench for the MAC slot timer
`timescale 1ns/1ps
module test_mac_slot_timer;
    import mst_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic tick_en = 1'b0;
    logic half = 1'b0;
    logic deep_sleep_resume = 1'b0;
    logic expiry_irq_unmask = 1'b0;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
    logic sfr_wr, sfr_rd, expiry_irq_flag, irq_req, expiry_dma_trigger, expiry_flag;
    int err_total = 0;
    int cmp_count = 0;
    int n_irqf = 0;
    int n_irq = 0;
    int n_dma = 0;
    int n;
    always #4 sys_clk = ~sys_clk;
    // Half rate ticking shows the prescaler only advances on ticks
    always @(negedge sys_clk) tick_en <= half ? ~tick_en : 1'b1;
    always @(negedge sys_clk) begin
        n_irqf += int'(expiry_irq_flag === 1'b1);
        n_irq += int'(irq_req === 1'b1);
        n_dma += int'(expiry_dma_trigger === 1'b1);
    end
    mst_cpu_model cpu (.sys_clk, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata);
    mst_slot_timer dut (.sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
        .tick_en, .deep_sleep_resume, .expiry_irq_unmask, .expiry_irq_flag, .irq_req,
        .expiry_dma_trigger, .expiry_flag);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wait_flag(input int lim);
        n = 0;
        while (expiry_flag !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            results();
        end
    endtask
    task automatic t_reset();
        logic [7:0] ad[4] = '{MST_ADDR_COUNT, MST_ADDR_PRESCALE, MST_ADDR_CONTROL, 8'ha0};
        foreach (ad[i]) begin
            cpu.rd(ad[i], v);
            check(v, 8'h00);
        end
        $display("t_reset done");
    endtask
    task automatic t_int();
        int pr[7] = '{1, 1, 1, 1, 3, 1, 0};
        int tp[7] = '{0, 1, 2, 3, 0, 0, 0};
        int ex[7] = '{64, 128, 256, 1024, 192, 128, 16384};
        for (int i = 0; i < 7; i++) begin
            half = (i == 5);
            cpu.wr(MST_ADDR_PRESCALE, 8'(pr[i]));
            cpu.wr(MST_ADDR_CONTROL, 8'(tp[i]));
            cpu.wr(MST_ADDR_COUNT, 8'h01);
            wait_flag(ex[i] + 50);
            check(8'(n >= ex[i] - 2 && n <= ex[i] + 6), 8'h01);
            cpu.rd(MST_ADDR_CONTROL, v);
            check(v, 8'(8'h40 + tp[i]));
            // Wait past one more full interval, so a count that wrapped would show
            repeat (ex[i] + 8) @(negedge sys_clk);
            cpu.rd(MST_ADDR_COUNT, v);
            check(v, 8'h00);
            cpu.wr(MST_ADDR_CONTROL, 8'(tp[i]));
            cpu.rd(MST_ADDR_CONTROL, v);
            check(v, 8'(tp[i]));
        end
        half = 1'b0;
        $display("t_int done");
    endtask
    task automatic t_irq();
        int a, b, c;
        cpu.wr(MST_ADDR_PRESCALE, 8'h01);
        for (int i = 0; i < 3; i++) begin
            expiry_irq_unmask = (i != 1);
            a = n_irqf;
            b = n_irq;
            c = n_dma;
            cpu.wr(MST_ADDR_CONTROL, (i == 0) ? 8'h00 : 8'h10);
            cpu.wr(MST_ADDR_COUNT, 8'h01);
            wait_flag(200);
            repeat (2) @(negedge sys_clk);
            check(8'(n_dma - c), 8'h01);
            check(8'(n_irqf - a), (i == 0) ? 8'h00 : 8'h01);
            check(8'(n_irq - b), (i == 2) ? 8'h01 : 8'h00);
            cpu.wr(MST_ADDR_CONTROL, 8'h00);
            cpu.wr(MST_ADDR_CONTROL, 8'h40);
            cpu.rd(MST_ADDR_CONTROL, v);
            check(v, 8'h00);
        end
        $display("t_irq done");
    endtask
    task automatic t_free();
        cpu.wr(MST_ADDR_CONTROL, 8'h04);
        cpu.wr(MST_ADDR_COUNT, 8'h01);
        wait_flag(200);
        repeat (32) @(negedge sys_clk);
        cpu.rd(MST_ADDR_COUNT, v);
        check(v, 8'h00);
        repeat (64) @(negedge sys_clk);
        cpu.rd(MST_ADDR_COUNT, v);
        check(v, 8'hff);
        // Free-running edges come every 64 cycles; this write lands on the one 128 after expiry
        repeat (26) @(negedge sys_clk);
        cpu.wr(MST_ADDR_COUNT, 8'h20);
        cpu.rd(MST_ADDR_COUNT, v);
        check(v, 8'h1f);
        cpu.wr(MST_ADDR_CONTROL, 8'h00);
        $display("t_free done");
    endtask
    task automatic t_sleep();
        cpu.wr(MST_ADDR_PRESCALE, 8'h10);
        cpu.wr(MST_ADDR_CONTROL, 8'h13);
        cpu.wr(MST_ADDR_COUNT, 8'h40);
        cpu.rd(MST_ADDR_COUNT, v);
        check(v, 8'h40);
        @(negedge sys_clk);
        deep_sleep_resume = 1'b1;
        @(negedge sys_clk);
        deep_sleep_resume = 1'b0;
        t_reset();
        $display("t_sleep done");
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_int();
        t_irq();
        t_free();
        t_sleep();
        results();
    end
endmodule
